/* core/bmiu_core.sv */
// Single-bit instruction execution unit with a classic Wishbone slave.
// Assumes one clock, an asynchronous active-low reset, and a single-cycle Wishbone master.
//
// What this block does
// - Opcode 57 inverts one bit, 4 cycles
// - Complement sets Z from bit, clears S
// - Opcode 77 variant 0 clears bit, no flags
// - Opcode 77 variant 1 sets bit, no flags
// - Byte two: register, bit index, variant
// - Bit OR either direction, Z from result, S cleared
// - Opcode 07, three bytes, 6 cycles
// - Bit OR leaves source and other bits
// - Opcode 37 variant 0 branches when clear
// - Signed displacement, branch changes no flags
// - Branch register and bit from byte two
// - Flags live at register 0D5H
// - Opcode 37 variant 1 branches when set
`timescale 1ns/100ps

module bmiu_core
  import bmiu_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [11:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic [15:0] PC_O
);

  typedef struct packed {
    logic [255:0][7:0] rf;
    logic [15:0] pc;
    logic [7:0] opc;
    logic [7:0] b2;
    logic [7:0] b3;
    bmiu_op_t op;
    logic [1:0] len;
    logic [3:0] cnt;
    bmiu_state_t st;
    logic illegal;
    logic taken;
    logic done;
    logic ack;
    logic [31:0] dat;
  } bmiu_regs_t;

  bmiu_regs_t q;
  bmiu_regs_t n;

  // Working register number maps into the register file
  function automatic logic [7:0] wreg_addr(input logic [3:0] num);
    wreg_addr = WREG_BASE | {4'h0, num};
  endfunction : wreg_addr

  // Sign-extended relative displacement
  function automatic logic [15:0] sext_disp(input logic [7:0] disp);
    sext_disp = {{8{disp[7]}}, disp};
  endfunction : sext_disp

  logic req;
  logic wr;
  logic [7:0] new_opc;
  logic [7:0] new_b2;
  logic [7:0] new_b3;
  bmiu_op_t dec_op;
  logic [3:0] dec_cycles;
  logic [1:0] dec_len;

  assign req = CYC_I & STB_I & ~q.ack;
  assign wr = req & WE_I;
  assign new_opc = SEL_I[0] ? DAT_I[7:0] : q.opc;
  assign new_b2 = SEL_I[1] ? DAT_I[15:8] : q.b2;
  assign new_b3 = SEL_I[2] ? DAT_I[23:16] : q.b3;

  bmiu_decode u_decode (
    .opcode(new_opc),
    .variant(new_b2[0]),
    .op(dec_op),
    .cycles(dec_cycles),
    .len(dec_len)
  );

  always_comb begin
    logic [7:0] wa;
    logic [7:0] ra;
    logic [2:0] bi;
    logic [7:0] data;
    logic res;
    logic tk;
    wa = wreg_addr(q.b2[7:4]);
    ra = q.b3;
    bi = q.b2[3:1];
    data = 8'h00;
    res = 1'b0;
    tk = 1'b0;
    n = q;
    n.ack = req;
    n.dat = 32'h0000_0000;

    // Register reads
    if (req && !WE_I) begin
      if (ADR_I == ADR_INSTR) begin
        n.dat = {8'h00, q.b3, q.b2, q.opc};
      end else if (ADR_I == ADR_PC) begin
        n.dat = {16'h0000, q.pc};
      end else if (ADR_I == ADR_STATUS) begin
        n.dat[ST_BUSY] = (q.st == S_EXEC);
        n.dat[ST_ILLEGAL] = q.illegal;
        n.dat[ST_TAKEN] = q.taken;
        n.dat[ST_DONE] = q.done;
      end else if (ADR_I[11:10] == ADR_RF_WINDOW) begin
        n.dat = {24'h000000, q.rf[ADR_I[9:2]]};
      end else begin
        n.dat = 32'h0000_0000;
      end
    end

    // Sticky status bits clear on write of one; a set below wins
    if (wr && ADR_I == ADR_STATUS && SEL_I[0]) begin
      if (DAT_I[ST_ILLEGAL]) begin
        n.illegal = 1'b0;
      end
      if (DAT_I[ST_DONE]) begin
        n.done = 1'b0;
      end
    end

    // Writes that need an idle unit
    if (wr && q.st == S_IDLE) begin
      if (ADR_I == ADR_PC) begin
        if (SEL_I[0]) begin
          n.pc[7:0] = DAT_I[7:0];
        end
        if (SEL_I[1]) begin
          n.pc[15:8] = DAT_I[15:8];
        end
      end else if (ADR_I[11:10] == ADR_RF_WINDOW && SEL_I[0]) begin
        n.rf[ADR_I[9:2]] = DAT_I[7:0];
      end else if (ADR_I == ADR_INSTR) begin
        n.opc = new_opc;
        n.b2 = new_b2;
        n.b3 = new_b3;
        if (SEL_I[0]) begin
          if (dec_op == OP_NONE) begin
            n.illegal = 1'b1;
          end else begin
            n.op = dec_op;
            n.len = dec_len;
            n.cnt = dec_cycles;
            n.st = S_EXEC;
          end
        end
      end
    end

    // Execution runs for the full cycle count and commits on the last one
    case (q.st)
      S_IDLE: begin
        n.cnt = (wr && q.st == S_IDLE && ADR_I == ADR_INSTR) ? n.cnt : 4'h0;
      end
      S_EXEC: begin
        n.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          n.st = S_IDLE;
          n.done = 1'b1;
          case (q.op)
            OP_BIT_COMPLEMENT_OP: begin
              data = q.rf[wa];
              res = ~data[bi];
              data[bi] = res;
              n.rf[wa] = data;
              n.rf[FLAGS_ADDR][FLG_Z] = ~res;
              n.rf[FLAGS_ADDR][FLG_S] = 1'b0;
            end
            OP_BIT_CLEAR_OP: begin
              data = q.rf[wa];
              data[bi] = 1'b0;
              n.rf[wa] = data;
            end
            OP_BITS: begin
              data = q.rf[wa];
              data[bi] = 1'b1;
              n.rf[wa] = data;
            end
            OP_BOR_TO_W: begin
              data = q.rf[wa];
              res = data[0] | q.rf[ra][bi];
              data[0] = res;
              n.rf[wa] = data;
              n.rf[FLAGS_ADDR][FLG_Z] = ~res;
              n.rf[FLAGS_ADDR][FLG_S] = 1'b0;
            end
            OP_BOR_TO_R: begin
              data = q.rf[ra];
              res = data[bi] | q.rf[wa][0];
              data[bi] = res;
              n.rf[ra] = data;
              n.rf[FLAGS_ADDR][FLG_Z] = ~res;
              n.rf[FLAGS_ADDR][FLG_S] = 1'b0;
            end
            OP_BR_CLR: begin
              tk = ~q.rf[wa][bi];
            end
            OP_BR_SET: begin
              tk = q.rf[wa][bi];
            end
            default: begin
              tk = 1'b0;
            end
          endcase
          n.taken = tk;
          // Flags untouched on the branch path
          n.pc = q.pc + {14'h0000, q.len} + (tk ? sext_disp(q.b3) : 16'h0000);
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign DAT_O = q.dat;
  assign ACK_O = q.ack;
  assign PC_O = q.pc;

endmodule : bmiu_core

/* core/bmiu_decode.sv */
// Package and opcode decoder for the single-bit instruction unit.
// Assumes the decoder sees the opcode and second instruction byte of a fetched instruction.
`timescale 1ns/100ps

package bmiu_pkg;
  // Opcodes
  localparam logic [7:0] OPC_BIT_COMPLEMENT = 8'h57;
  localparam logic [7:0] OPC_BIT_CLR_SET = 8'h07 + 8'h70;
  localparam logic [7:0] OPC_BIT_OR = 8'h07;
  localparam logic [7:0] OPC_TEST_BRANCH = 8'h37;
  // Cycle counts and instruction lengths
  localparam logic [3:0] CYC_BIT_2BYTE = 4'h4;
  localparam logic [3:0] CYC_BIT_OR = 4'h6;
  localparam logic [3:0] CYC_BRANCH = 4'ha;
  localparam logic [1:0] LEN_2BYTE = 2'h2;
  localparam logic [1:0] LEN_3BYTE = 2'h3;
  // Register file layout
  localparam logic [7:0] FLAGS_ADDR = 8'hd5;
  localparam logic [7:0] WREG_BASE = 8'hc0;
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  // Wishbone byte offsets, and the register window select in address bits 11:10
  localparam logic [11:0] ADR_INSTR = 12'h000;
  localparam logic [11:0] ADR_PC = 12'h004;
  localparam logic [11:0] ADR_STATUS = 12'h008;
  localparam logic [1:0] ADR_RF_WINDOW = 2'h1;
  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_ILLEGAL = 1;
  localparam int ST_TAKEN = 2;
  localparam int ST_DONE = 3;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_BIT_COMPLEMENT_OP = 3'b001,
    OP_BIT_CLEAR_OP = 3'b010,
    OP_BITS = 3'b011,
    OP_BOR_TO_W = 3'b100,
    OP_BOR_TO_R = 3'b101,
    OP_BR_CLR = 3'b110,
    OP_BR_SET = 3'b111
  } bmiu_op_t;

  typedef enum logic {
    S_IDLE = 1'b0,
    S_EXEC = 1'b1
  } bmiu_state_t;
endpackage : bmiu_pkg

module bmiu_decode
  import bmiu_pkg::*;
(
  input wire logic [7:0] opcode,
  input wire logic variant,
  output bmiu_op_t op,
  output logic [3:0] cycles,
  output logic [1:0] len
);

  always_comb begin
    op = OP_NONE;
    cycles = 4'h0;
    len = 2'h0;
    case (opcode)
      OPC_BIT_COMPLEMENT: begin
        op = OP_BIT_COMPLEMENT_OP;
        cycles = CYC_BIT_2BYTE;
        len = LEN_2BYTE;
      end
      OPC_BIT_CLR_SET: begin
        op = variant ? OP_BITS : OP_BIT_CLEAR_OP;
        cycles = CYC_BIT_2BYTE;
        len = LEN_2BYTE;
      end
      OPC_BIT_OR: begin
        op = variant ? OP_BOR_TO_R : OP_BOR_TO_W;
        cycles = CYC_BIT_OR;
        len = LEN_3BYTE;
      end
      OPC_TEST_BRANCH: begin
        op = variant ? OP_BR_SET : OP_BR_CLR;
        cycles = CYC_BRANCH;
        len = LEN_3BYTE;
      end
      default: begin
        op = OP_NONE;
      end
    endcase
  end

endmodule : bmiu_decode

/* test/bmiu_core_monitor.sv */
// Port checker for the single-bit instruction unit.
// Assumes instructions are written only while the unit is idle.
`timescale 1ns/100ps
module bmiu_core_monitor
  import bmiu_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [11:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic [15:0] PC_O
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  logic req;
  assign req = CYC_I && STB_I && WE_I && !ACK_O;
  sequence s_op(logic [7:0] op);
    req && ADR_I == ADR_INSTR && SEL_I[0] && DAT_I[7:0] == op;
  endsequence
  sequence s_hold4;
    $stable(PC_O)[*4];
  endsequence
  AST_ACK_NEXT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("no ack");
  AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  AST_DAT_IDLE: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("data outside ack");
  AST_PC_WRITE: assert property (req && ADR_I == ADR_PC && SEL_I == 4'h3
    |=> PC_O == $past(DAT_I[15:0])) else $error("pc write lost");
  AST_BIT_COMPLEMENT_OP_TIME:
    assert property (s_op(OPC_BIT_COMPLEMENT) |=> s_hold4 ##1 PC_O == $past(PC_O) + 16'h2)
    else $error("complement timing");
  AST_CLR_SET_TIME:
    assert property (s_op(OPC_BIT_CLR_SET) |=> s_hold4 ##1 PC_O == $past(PC_O) + 16'h2)
    else $error("clear or set timing");
  AST_BOR_TIME:
    assert property (s_op(OPC_BIT_OR) |=> $stable(PC_O)[*6] ##1 PC_O == $past(PC_O) + 16'h3)
    else $error("bit or timing");
  AST_BRANCH:
    assert property (s_op(OPC_TEST_BRANCH) |=> s_hold4 ##1 s_hold4 ##1 $stable(PC_O)[*2]
      ##1 PC_O - $past(PC_O) - 16'h3 + 16'h80 < 16'h100) else $error("branch timing");
endmodule : bmiu_core_monitor
bind bmiu_core bmiu_core_monitor bmiu_core_monitor_inst (.CLK(CLK), .RSTN(RSTN),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
  .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .PC_O(PC_O));

/* test/bmiu_core_bench.sv */
// Random and corner-case bench for the single-bit instruction unit.
// Assumes bus answers within 9 cycles and the register window at 0x400.
`timescale 1ns/100ps
module bmiu_core_bench;
  import bmiu_pkg::*;
  logic CLK = 1'h0, RSTN = 1'h0, CYC_I = 1'h0, STB_I = 1'h0, WE_I = 1'h0, ACK_O;
  logic [11:0] ADR_I = 12'h0;
  logic [3:0] SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0, DAT_O, q, lfsr = 32'h4e52d75f;
  logic [15:0] PC_O;
  logic [7:0] rf [256];
  logic [8:0] tbl [7] = '{9'h057, 9'h077, 9'h177, 9'h007, 9'h107, 9'h037, 9'h137};
  int error_cnt = 0, comparisons = 0;
  bmiu_core bmiu_core_inst (.CLK(CLK), .RSTN(RSTN), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .PC_O(PC_O));
  always #5 CLK = ~CLK;
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int i;
    @(posedge CLK);
    {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} <= {2'h3, w, a, s, d};
    for (i = 0; i < 9; i++) begin
      @(negedge CLK);
      if (ACK_O === 1'h1) break;
    end
    if (i == 9) begin
      error_cnt++;
      $display("ERROR %0t no bus answer", $time);
      print_verdict();
    end
    q = DAT_O;
    @(posedge CLK);
    {CYC_I, STB_I} <= 2'h0;
  endtask : bus
  task automatic run(input logic [8:0] c, input logic [3:0] n, input logic [2:0] b,
    input logic [7:0] b3);
    logic [7:0] ad [3];
    logic [15:0] pc;
    logic r;
    logic t;
    int k;
    ad = '{WREG_BASE + {4'h0, n}, b3, FLAGS_ADDR};
    pc = lfsr[15:0];
    bus(1'h1, ADR_PC, 4'h3, {16'h0, pc});
    for (k = 0; k < 3; k++) begin
      lfsr = step(lfsr);
      rf[ad[k]] = lfsr[7:0];
      bus(1'h1, 12'h400 + {2'h0, ad[k], 2'h0}, 4'h1, {24'h0, lfsr[7:0]});
    end
    bus(1'h1, ADR_INSTR, 4'h7, {8'h0, b3, n, b, c});
    r = c[8] ? rf[b3][b] | rf[ad[0]][0] : rf[ad[0]][0] | rf[b3][b];
    t = rf[ad[0]][b] == c[8];
    if (c[7:0] == OPC_BIT_COMPLEMENT) r = ~rf[ad[0]][b];
    if (c[7:0] == OPC_BIT_COMPLEMENT) rf[ad[0]][b] = r;
    if (c[7:0] == OPC_BIT_CLR_SET) rf[ad[0]][b] = c[8];
    if (c == 9'h107) rf[b3][b] = r;
    if (c == 9'h007) rf[ad[0]][0] = r;
    if (c[7:0] inside {OPC_BIT_COMPLEMENT, OPC_BIT_OR}) rf[FLAGS_ADDR][FLG_Z -: 2] = {~r, 1'h0};
    for (k = 0; k < 20; k++) begin
      bus(1'h0, ADR_STATUS, 4'hf, 32'h0);
      if (q[ST_BUSY] === 1'h0) break;
    end
    if (k == 20) error_cnt++;
    if (k == 20) print_verdict();
    for (k = 0; k < 3; k++) begin
      bus(1'h0, 12'h400 + {2'h0, ad[k], 2'h0}, 4'h1, 32'h0);
      check(q, {24'h0, rf[ad[k]]});
    end
    t = t && c[7:0] == OPC_TEST_BRANCH;
    bus(1'h0, ADR_STATUS, 4'hf, 32'h0);
    check({31'h0, q[ST_DONE]}, 32'h1);
    check({31'h0, q[ST_TAKEN]}, {31'h0, t});
    pc = pc + ((c[7:0] inside {OPC_BIT_COMPLEMENT, OPC_BIT_CLR_SET}) ? 16'h2 : 16'h3);
    check({16'h0, PC_O}, {16'h0, pc + (t ? {{8{b3[7]}}, b3} : 16'h0)});
    $display("test %h done", c);
  endtask : run
  initial begin
    repeat (16) @(posedge CLK);
    RSTN <= 1'h1;
    bus(1'h0, 12'h010, 4'hf, 32'h0);
    check(q, 32'h0);
    bus(1'h1, ADR_INSTR, 4'h1, 32'h0);
    bus(1'h0, ADR_STATUS, 4'hf, 32'h0);
    check({31'h0, q[ST_ILLEGAL]}, 32'h1);
    run(9'h037, 4'h1, 3'h3, 8'h7f);
    run(9'h137, 4'hf, 3'h7, 8'h80);
    run(9'h107, 4'h0, 3'h7, FLAGS_ADDR);
    repeat (60) begin
      lfsr = step(lfsr);
      run(tbl[lfsr % 7], lfsr[11:8], lfsr[14:12], lfsr[23:16]);
    end
    print_verdict();
  end
endmodule : bmiu_core_bench
